// >>> hw/csoc_pkg.sv
/*
 * Package for the capacitive-sense oscillator control block: register
 * offsets, field positions, reset values and mode codes.
 * Assumes a plain register port with 8-bit data, registers at the offsets
 * below.
 */
package csoc_pkg;

   // register offsets (byte index on the plain port)
   localparam logic [3:0] SENSE_CONTROL_0_ADDR        = 4'h0;
   localparam logic [3:0] SENSE_CHANNEL_SELECT_ADDR   = 4'h1;
   localparam logic [3:0] TIMER8_OPTION_ADDR          = 4'h2;
   localparam logic [3:0] TIMER16_CONTROL_ADDR        = 4'h3;
   localparam logic [3:0] TIMER16_GATE_CTRL_ADDR      = 4'h4;
   localparam logic [3:0] SENSE_MODE_STATUS_ADDR      = 4'h5;

   // sense_control_0 fields
   localparam int MODULE_ENABLE_POS   = 7;
   localparam int REF_MODE_POS        = 6;
   localparam int RANGE_LSB_POS       = 2;
   localparam int STATUS_POS          = 1;
   localparam int SENSE_CLK_SEL_POS   = 0;

   // channel select field
   localparam int CHANNEL_W           = 5;
   localparam int NUM_CHANNELS        = 17;

   // timer8 option register: clock source bit position
   localparam int TIMER8_CS_POS       = 5;

   // timer16 control register fields
   localparam int T16_CS_LSB_POS      = 6;
   localparam int T16_ON_POS          = 0;
   // timer16 gate control register: gate enable bit
   localparam int T16_GE_POS          = 7;

   // reset values
   localparam logic [7:0] SENSE_CONTROL_0_RST   = 8'h00;
   localparam logic [7:0] CHANNEL_SELECT_RST    = 8'h00;
   localparam logic [7:0] TIMER8_OPTION_RST     = 8'h00;
   localparam logic [7:0] TIMER16_CONTROL_RST   = 8'h00;
   localparam logic [7:0] TIMER16_GATE_RST      = 8'h00;

   // current range codes
   typedef enum logic [1:0] {
      CSOC_RNG_OFF_NOISE = 2'h0,
      CSOC_RNG_LOW       = 2'h1,
      CSOC_RNG_MEDIUM    = 2'h2,
      CSOC_RNG_HIGH      = 2'h3
   } csoc_range_t;

   // timer16 clock source code that picks the sense oscillator
   localparam logic [1:0] T16_CS_SENSE_OSC = 2'h3;

   // decoded power mode, one-hot, all zero when off
   typedef enum logic [6:0] {
      CSOC_PM_OFF      = 7'h00,
      CSOC_PM_LO_LOW   = 7'h01,
      CSOC_PM_LO_MED   = 7'h02,
      CSOC_PM_LO_HIGH  = 7'h04,
      CSOC_PM_HI_NOISE = 7'h08,
      CSOC_PM_HI_LOW   = 7'h10,
      CSOC_PM_HI_MED   = 7'h20,
      CSOC_PM_HI_HIGH  = 7'h40
   } csoc_pmode_t;

   // synchroniser depth for pin inputs
   localparam int SYNC_STAGES = 3;

endpackage : csoc_pkg

// >>> hw/csoc_sync.sv
/*
 * Three-stage synchroniser with agreement filter: the output changes once
 * the second and third stages agree.
 * Assumes a single clock, a synchronous active-high reset and a clock enable.
 */
`timescale 1ns/1ns
`default_nettype none

module csoc_sync (
   // clock and control
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   // data
   input  wire logic async_in,
   output var  logic sync_out
);

   logic [csoc_pkg::SYNC_STAGES-1:0] stage_q;
   logic                             out_q;
   wire                              agree = (stage_q[1] == stage_q[2]);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stage_q <= '0;
         out_q   <= 1'b0;
      end else if (clk_en) begin
         stage_q <= {stage_q[1:0], async_in};
         if (agree) begin
            out_q <= stage_q[2];
         end
      end
   end

   assign sync_out = out_q;

endmodule : csoc_sync

`default_nettype wire

// >>> hw/csoc_ctrl.sv
/*
 * Control logic for a capacitive-sense relaxation oscillator: reference and
 * current-range mode decode, sink/source status, channel routing, and
 * routing of the oscillator as count clock into an 8-bit and a 16-bit
 * timer, with the 16-bit timer's enable and gate function.
 * Assumes the analog oscillator, timers and gate source sit outside; the
 * oscillator output and the gate arrive as asynchronous pins.
 */
// Local design decisions: strobed register access and the register offsets.
// Functional notes
// - sink/source status bit of the oscillator is readable.
// - oscillator output can clock the 8-bit or 16-bit timer.
// - reference-mode bit picks variable references when set, rails when clear.
// - range codes 01/10/11 give low/medium/high; 00 is off in low range.
// - in high range code 00 selects noise detection; seven modes total.
// - noise mode stops pin current, comparator stays active.
// - sensing-clock select bit set supplies the oscillator to the 8-bit timer.
// - 16-bit timer clock-source field 11 selects the sense oscillator.
// - 16-bit timer off when on bit 0; gate enable makes it gated.
// - module enable bit turns the sensing module on or off.
// - clock select chooses oscillator or pin only if 8-bit timer external.
// - while enabled, the selected channel pin carries the oscillator.
`timescale 1ns/1ns
`default_nettype none

module csoc_ctrl #(
   parameter int NUM_CHANNELS = csoc_pkg::NUM_CHANNELS
) (
   // clock, reset, enable
   input  wire logic                    ref_clk,
   input  wire logic                    sys_rst,
   input  wire logic                    clk_en,
   // register port
   input  wire logic [3:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output var  logic [7:0]              reg_rdata,
   // oscillator analog core
   input  wire logic                    osc_comp_in,
   output var  logic                    osc_enable,
   output var  logic                    osc_ref_variable,
   output var  logic                    osc_source_en,
   output var  logic                    osc_sink_en,
   output var  logic [1:0]              osc_current_sel,
   output var  logic                    osc_high_range,
   output var  logic [NUM_CHANNELS-1:0] sense_channel_pin_en,
   // timer clock routing
   input  wire logic                    timer8_ext_pin,
   input  wire logic                    instr_clk_tick,
   output var  logic                    timer8_count_clk,
   output var  logic                    timer16_sense_clk,
   // timer16 enable and gate
   input  wire logic                    timer16_gate_in,
   output var  logic                    timer16_count_en
);

   ////////////////////////////////////////////////////////////////////////
   // registers

   logic [7:0] sense_control_0_q;
   logic [7:0] sense_channel_select_reg_q;
   logic [7:0] timer8_option_q;
   logic [7:0] timer16_control_register_q;
   logic [7:0] timer16_gate_q;
   logic [7:0] reg_rdata_q;

   wire wr_ctl0  = reg_wr && reg_addr == csoc_pkg::SENSE_CONTROL_0_ADDR;
   wire wr_chan  = reg_wr && reg_addr == csoc_pkg::SENSE_CHANNEL_SELECT_ADDR;
   wire wr_t8    = reg_wr && reg_addr == csoc_pkg::TIMER8_OPTION_ADDR;
   wire wr_t16   = reg_wr && reg_addr == csoc_pkg::TIMER16_CONTROL_ADDR;
   wire wr_t16g  = reg_wr && reg_addr == csoc_pkg::TIMER16_GATE_CTRL_ADDR;

   ////////////////////////////////////////////////////////////////////////
   // field views

   wire sense_module_enable =
      sense_control_0_q[csoc_pkg::MODULE_ENABLE_POS];
   wire reference_mode_bit =
      sense_control_0_q[csoc_pkg::REF_MODE_POS];
   wire [1:0] current_range_field =
      sense_control_0_q[csoc_pkg::RANGE_LSB_POS +: 2];
   wire timer8_sense_clock_select =
      sense_control_0_q[csoc_pkg::SENSE_CLK_SEL_POS];
   wire [csoc_pkg::CHANNEL_W-1:0] sense_channel_field =
      sense_channel_select_reg_q[csoc_pkg::CHANNEL_W-1:0];
   wire timer8_clock_source_bit =
      timer8_option_q[csoc_pkg::TIMER8_CS_POS];
   wire [1:0] timer16_clock_source_field =
      timer16_control_register_q[csoc_pkg::T16_CS_LSB_POS +: 2];
   wire timer16_on_bit =
      timer16_control_register_q[csoc_pkg::T16_ON_POS];
   wire timer16_gate_enable =
      timer16_gate_q[csoc_pkg::T16_GE_POS];

   ////////////////////////////////////////////////////////////////////////
   // oscillator, timer8 pin and gate input synchronisers

   logic osc_sync;
   logic t8_pin_sync;
   logic gate_sync;

   csoc_sync u_osc_sync (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .async_in (osc_comp_in),
      .sync_out (osc_sync)
   );

   csoc_sync u_t8_pin_sync (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .async_in (timer8_ext_pin),
      .sync_out (t8_pin_sync)
   );

   csoc_sync u_gate_sync (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .async_in (timer16_gate_in),
      .sync_out (gate_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // mode decode

   csoc_pkg::csoc_pmode_t pmode;

   always_comb begin
      pmode = csoc_pkg::CSOC_PM_OFF;
      if (!sense_module_enable) begin
         pmode = csoc_pkg::CSOC_PM_OFF;
      end else if (reference_mode_bit) begin
         case (current_range_field)
            csoc_pkg::CSOC_RNG_OFF_NOISE: pmode = csoc_pkg::CSOC_PM_HI_NOISE;
            csoc_pkg::CSOC_RNG_LOW:       pmode = csoc_pkg::CSOC_PM_HI_LOW;
            csoc_pkg::CSOC_RNG_MEDIUM:    pmode = csoc_pkg::CSOC_PM_HI_MED;
            default:                      pmode = csoc_pkg::CSOC_PM_HI_HIGH;
         endcase
      end else begin
         case (current_range_field)
            csoc_pkg::CSOC_RNG_OFF_NOISE: pmode = csoc_pkg::CSOC_PM_OFF;
            csoc_pkg::CSOC_RNG_LOW:       pmode = csoc_pkg::CSOC_PM_LO_LOW;
            csoc_pkg::CSOC_RNG_MEDIUM:    pmode = csoc_pkg::CSOC_PM_LO_MED;
            default:                      pmode = csoc_pkg::CSOC_PM_LO_HIGH;
         endcase
      end
   end

   wire osc_on_d    = (pmode != csoc_pkg::CSOC_PM_OFF);
   wire noise_mode  = (pmode == csoc_pkg::CSOC_PM_HI_NOISE);
   wire drive_d     = osc_on_d && !noise_mode;
   wire status_bit  = osc_on_d && osc_sync;

   ////////////////////////////////////////////////////////////////////////
   // channel routing

   logic [NUM_CHANNELS-1:0] chan_en_d;

   for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
      assign chan_en_d[c] = sense_module_enable &&
         (sense_channel_field == csoc_pkg::CHANNEL_W'(c));
   end

   ////////////////////////////////////////////////////////////////////////
   // timer clock routing and timer16 enable

   wire t8_ext_clk = timer8_sense_clock_select ? osc_sync
                                               : t8_pin_sync;
   wire t8_clk_d   = timer8_clock_source_bit ? t8_ext_clk
                                             : instr_clk_tick;
   wire t16_sel    = (timer16_clock_source_field ==
                      csoc_pkg::T16_CS_SENSE_OSC);
   wire t16_clk_d  = t16_sel && osc_sync;
   wire t16_en_d   = timer16_on_bit &&
                     (!timer16_gate_enable || gate_sync);

   ////////////////////////////////////////////////////////////////////////
   // read mux

   logic [7:0] ctl0_view;
   logic [7:0] rd_mux;

   always_comb begin
      ctl0_view = sense_control_0_q & 8'hcd;
      ctl0_view[csoc_pkg::STATUS_POS] = status_bit;
      rd_mux = 8'h00;
      if (reg_addr == csoc_pkg::SENSE_CONTROL_0_ADDR) begin
         rd_mux = ctl0_view;
      end else if (reg_addr == csoc_pkg::SENSE_CHANNEL_SELECT_ADDR) begin
         rd_mux = sense_channel_select_reg_q & 8'h1f;
      end else if (reg_addr == csoc_pkg::TIMER8_OPTION_ADDR) begin
         rd_mux = timer8_option_q;
      end else if (reg_addr == csoc_pkg::TIMER16_CONTROL_ADDR) begin
         rd_mux = timer16_control_register_q;
      end else if (reg_addr == csoc_pkg::TIMER16_GATE_CTRL_ADDR) begin
         rd_mux = timer16_gate_q;
      end else if (reg_addr == csoc_pkg::SENSE_MODE_STATUS_ADDR) begin
         rd_mux = {1'b0, pmode};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sense_control_0_q <= csoc_pkg::SENSE_CONTROL_0_RST;
      end else if (clk_en && wr_ctl0) begin
         sense_control_0_q <= reg_wdata & 8'hcd;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sense_channel_select_reg_q <= csoc_pkg::CHANNEL_SELECT_RST;
      end else if (clk_en && wr_chan) begin
         sense_channel_select_reg_q <= reg_wdata & 8'h1f;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         timer8_option_q <= csoc_pkg::TIMER8_OPTION_RST;
      end else if (clk_en && wr_t8) begin
         timer8_option_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         timer16_control_register_q <= csoc_pkg::TIMER16_CONTROL_RST;
      end else if (clk_en && wr_t16) begin
         timer16_control_register_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         timer16_gate_q <= csoc_pkg::TIMER16_GATE_RST;
      end else if (clk_en && wr_t16g) begin
         timer16_gate_q <= reg_wdata;
      end
   end

   // read data stands one cycle, zero otherwise
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reg_rdata_q <= 8'h00;
      end else if (clk_en) begin
         reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // registered oscillator outputs
   // source and sink follow the synchronised phase, never both
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         osc_enable       <= 1'b0;
         osc_ref_variable <= 1'b0;
         osc_source_en    <= 1'b0;
         osc_sink_en      <= 1'b0;
         osc_current_sel  <= 2'h0;
         osc_high_range   <= 1'b0;
      end else if (clk_en) begin
         osc_enable       <= osc_on_d;
         osc_ref_variable <= reference_mode_bit;
         osc_source_en    <= drive_d && !osc_sync;
         osc_sink_en      <= drive_d && osc_sync;
         osc_current_sel  <= current_range_field;
         osc_high_range   <= reference_mode_bit;
      end
   end

   // registered channel pin enables
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sense_channel_pin_en <= '0;
      end else if (clk_en) begin
         sense_channel_pin_en <= chan_en_d;
      end
   end

   // registered timer clocks and enable
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         timer8_count_clk  <= 1'b0;
         timer16_sense_clk <= 1'b0;
         timer16_count_en  <= 1'b0;
      end else if (clk_en) begin
         timer8_count_clk  <= t8_clk_d;
         timer16_sense_clk <= t16_clk_d;
         timer16_count_en  <= t16_en_d;
      end
   end

   assign reg_rdata = reg_rdata_q;

endmodule : csoc_ctrl

`default_nettype wire

// >>> tb/csoc_ctrl_asserts.sv
/* Checker for csoc_ctrl: shadows the control registers from the
   register port and ties mode, channel and timer outputs to them.
   Assumes clk_en drops only while the outputs are settled. */
`timescale 1ns/1ns
`default_nettype none
module csoc_ctrl_asserts #(
   parameter int NUM_CHANNELS = 17
) (
   // clock and register port
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // oscillator and timers
   input wire logic osc_enable,
   input wire logic osc_ref_variable,
   input wire logic osc_source_en,
   input wire logic osc_sink_en,
   input wire logic [1:0] osc_current_sel,
   input wire logic osc_high_range,
   input wire logic [NUM_CHANNELS-1:0] sense_channel_pin_en,
   input wire logic instr_clk_tick,
   input wire logic timer8_count_clk,
   input wire logic timer16_sense_clk,
   input wire logic timer16_count_en
);
   logic [7:0] ctl_q;
   logic [7:0] t16_q;
   logic ge_q;
   logic t8x_q;
   wire [1:0] rng = ctl_q[3:2];
   wire on = ctl_q[7] & (ctl_q[6] | (rng != 2'h0));
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctl_q <= 8'h00;
         t16_q <= 8'h00;
         ge_q <= 1'b0;
         t8x_q <= 1'b0;
      end else if (reg_wr && clk_en) begin
         if (reg_addr == 4'h0) ctl_q <= reg_wdata;
         if (reg_addr == 4'h2) t8x_q <= reg_wdata[5];
         if (reg_addr == 4'h3) t16_q <= reg_wdata;
         if (reg_addr == 4'h4) ge_q <= reg_wdata[7];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_rd_ctl;
      reg_rd && reg_addr == 4'h0;
   endsequence
   sequence s_noise;
      on && rng == 2'h0;
   endsequence
   a_ctl_readback: assert property (s_rd_ctl |=>
      {reg_rdata[7:6], reg_rdata[3:2], reg_rdata[0]} ==
      $past({ctl_q[7:6], ctl_q[3:2], ctl_q[0]}))
      else $error("control readback wrong");
   a_ref_mode_sel: assert property (on |=>
      osc_ref_variable == $past(ctl_q[6]))
      else $error("reference mode wrong");
   a_range_decode: assert property (on |=> osc_enable &&
      osc_current_sel == $past(rng) && osc_high_range == $past(ctl_q[6]))
      else $error("range decode wrong");
   a_osc_off: assert property (!on |=> !osc_enable)
      else $error("oscillator not off");
   a_noise_idle: assert property (s_noise |=>
      osc_enable && !osc_source_en && !osc_sink_en)
      else $error("noise mode drives pin");
   a_chan_disabled: assert property (!ctl_q[7] |=>
      sense_channel_pin_en == '0)
      else $error("channel driven while off");
   a_t16_off: assert property (!t16_q[0] |=> !timer16_count_en)
      else $error("timer16 counts while off");
   a_t16_free: assert property (t16_q[0] && !ge_q |=> timer16_count_en)
      else $error("timer16 not free running");
   a_t16_src: assert property (t16_q[7:6] != 2'h3 |=> !timer16_sense_clk)
      else $error("timer16 sense clock leaks");
   a_t8_instr: assert property (!t8x_q |=>
      timer8_count_clk == $past(instr_clk_tick))
      else $error("timer8 not on tick");
endmodule : csoc_ctrl_asserts
bind csoc_ctrl csoc_ctrl_asserts #(.NUM_CHANNELS(NUM_CHANNELS)) u_asserts (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_enable(osc_enable),
   .osc_ref_variable(osc_ref_variable), .osc_source_en(osc_source_en),
   .osc_sink_en(osc_sink_en), .osc_current_sel(osc_current_sel),
   .osc_high_range(osc_high_range),
   .sense_channel_pin_en(sense_channel_pin_en),
   .instr_clk_tick(instr_clk_tick), .timer8_count_clk(timer8_count_clk),
   .timer16_sense_clk(timer16_sense_clk),
   .timer16_count_en(timer16_count_en)
);
`default_nettype wire

// >>> tb/csoc_timer_model.sv
/* Timer pair model: counts rising edges of the routed count clocks.
   Assumes count clocks already in the ref_clk domain. */
`timescale 1ns/1ns
`default_nettype none
module csoc_timer_model (
   // clock and clear
   input  wire logic        ref_clk,
   input  wire logic        clr,
   // count clocks
   input  wire logic        timer8_count_clk,
   input  wire logic        timer16_sense_clk,
   input  wire logic        timer16_count_en,
   // counts
   output var  logic [15:0] t8_cnt,
   output var  logic [15:0] t16_cnt
);
   logic t8_q;
   logic t16_q;
   always_ff @(posedge ref_clk) begin
      t8_q <= timer8_count_clk;
      t16_q <= timer16_sense_clk;
      if (clr) begin
         t8_cnt <= 16'h0000;
         t16_cnt <= 16'h0000;
      end else begin
         if (timer8_count_clk && !t8_q) t8_cnt <= t8_cnt + 16'h0001;
         if (timer16_sense_clk && !t16_q && timer16_count_en)
            t16_cnt <= t16_cnt + 16'h0001;
      end
   end
endmodule : csoc_timer_model
`default_nettype wire

// >>> tb/cap_sense_osc_control_bench.sv
/* Self-checking bench for csoc_ctrl with a timer pair model.
   Assumes csoc_pkg, csoc_sync and csoc_ctrl compiled first. */
`timescale 1ns/1ns
`default_nettype none
module cap_sense_osc_control_bench;
   logic ref_clk, sys_rst, clk_en, reg_wr, reg_rd, osc_comp_in;
   logic timer8_ext_pin, instr_clk_tick, timer16_gate_in;
   logic timer8_count_clk, timer16_sense_clk, timer16_count_en;
   logic clr, osc_run, rd_seen;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [16:0] pin_en;
   logic [15:0] t8_cnt, t16_cnt;
   logic [7:0] exp_q[$];
   int err_count, samples_checked, cyc, osc_div, nom;
   csoc_ctrl u_csoc_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .osc_comp_in(osc_comp_in), .osc_enable(), .osc_ref_variable(),
      .osc_source_en(), .osc_sink_en(), .osc_current_sel(),
      .osc_high_range(), .sense_channel_pin_en(pin_en),
      .timer8_ext_pin(timer8_ext_pin), .instr_clk_tick(instr_clk_tick),
      .timer8_count_clk(timer8_count_clk),
      .timer16_sense_clk(timer16_sense_clk),
      .timer16_gate_in(timer16_gate_in),
      .timer16_count_en(timer16_count_en));
   csoc_timer_model u_csoc_timer_model (.ref_clk(ref_clk), .clr(clr),
      .timer8_count_clk(timer8_count_clk),
      .timer16_sense_clk(timer16_sense_clk),
      .timer16_count_en(timer16_count_en), .t8_cnt(t8_cnt),
      .t16_cnt(t16_cnt));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      @(posedge ref_clk);
   endtask : rd
   task automatic idle(input int n);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      repeat (n) @(posedge ref_clk);
   endtask : idle
   task automatic count();
      clr <= 1'b1;
      idle(12);
      clr <= 1'b0;
      repeat (400) @(posedge ref_clk);
   endtask : count
   function automatic logic [7:0] pmode(input logic [7:0] d);
      if (!d[7]) return 8'h00;
      if (d[6]) return 8'h08 << d[3:2];
      return (d[3:2] == 2'h0) ? 8'h00 : 8'h01 << (d[3:2] - 2'h1);
   endfunction : pmode
   // read results land one cycle after the strobe
   always @(posedge ref_clk) begin
      if (rd_seen) chk({24'h0, reg_rdata}, {24'h0, exp_q.pop_front()});
      rd_seen <= reg_rd & ~sys_rst;
   end
   // oscillator, pin and tick stimulus, hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      instr_clk_tick <= 1'($urandom);
      if (osc_run && cyc % osc_div == 0) osc_comp_in <= ~osc_comp_in;
      if (cyc % 6 == 0) timer8_ext_pin <= ~timer8_ext_pin;
      if (cyc == 6000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      logic [7:0] d;
      int s;
      s = $urandom(32'h0085c04f);
      {sys_rst, clk_en, osc_comp_in} = 3'h7;
      {reg_wr, reg_rd, clr, osc_run, rd_seen} = 5'h00;
      {timer8_ext_pin, instr_clk_tick, timer16_gate_in} = 3'h0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      {err_count, samples_checked, cyc} = {32'h0, 32'h0, 32'h0};
      osc_div = 10;
      nom = 0;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
      for (int m = 0; m < 16; m++) begin
         d = {m[3], m[2], 2'($urandom), m[1:0], 2'($urandom)};
         wr(4'h0, d);
         idle(2);
         rd(4'h0, {d[7:6], 2'h0, d[3:2],
            d[7] & (d[6] | d[3:2] != 2'h0), d[0]});
         rd(4'h5, pmode(d));
      end
      wr(4'h0, 8'h80);
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 8'h10 : (i == 1) ? 8'hf1 : 8'($urandom);
         wr(4'h1, d);
         idle(2);
         rd(4'h1, {3'h0, d[4:0]});
         chk({15'h0, pin_en}, (d[4:0] > 5'h10) ? 0 : 32'h1 << d[4:0]);
      end
      wr(4'h0, 8'h00);
      idle(2);
      chk({15'h0, pin_en}, 32'h0);
      for (int k = 0; k < 8; k++) begin
         timer16_gate_in <= k[0];
         wr(4'h3, {2'h3, 5'h00, k[2]});
         wr(4'h4, {k[1], 7'h00});
         idle(8);
         rd(4'h3, {2'h3, 5'h00, k[2]});
         chk({31'h0, timer16_count_en}, {31'h0, k[2] & (~k[1] | k[0])});
      end
      wr(4'h4, 8'h00);
      wr(4'h2, 8'h20);
      wr(4'h0, 8'h8d);
      osc_run <= 1'b1;
      count();
      chk({31'h0, t16_cnt inside {[19:21]}}, 32'h1);
      chk({31'h0, t8_cnt inside {[19:21]}}, 32'h1);
      nom = t16_cnt;
      osc_div <= 16;
      wr(4'h0, 8'h8c);
      count();
      chk({31'h0, t8_cnt inside {[32:35]}}, 32'h1);
      chk({31'h0, t16_cnt inside {[11:14]}}, 32'h1);
      chk({31'h0, t16_cnt < (nom + t16_cnt) / 2}, 32'h1);
      osc_run <= 1'b0;
      idle(1);
      osc_comp_in <= 1'b0;
      idle(8);
      rd(4'h0, 8'h8c);
      clk_en <= 1'b0;
      wr(4'h0, 8'h00);
      idle(1);
      clk_en <= 1'b1;
      rd(4'h5, 8'h04);
      idle(3);
      print_verdict();
   end
endmodule : cap_sense_osc_control_bench
`default_nettype wire
